// ===== design/hub_fs_descriptor_source.sv
// full-speed interface/endpoint and hub class descriptor byte source
//
// Added by the designer: the address map and the AHB-Lite register port.
module hub_fs_descriptor_source
    import hub_desc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // descriptor request from the usb core
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_type,
    output logic             req_ready,
    output logic             req_reject,
    // descriptor byte stream to the usb core
    output logic             out_valid,
    output logic [7:0]       out_data,
    output logic             out_last,
    input  wire logic        out_ready
);

    // ----------------------------------------------------------------
    // byte lookup
    // ----------------------------------------------------------------
    function automatic logic [7:0] desc_len(input desc_kind_t k);
        unique case (k)
            KIND_IFACE: desc_len = LEN_IFACE;
            KIND_EP:    desc_len = LEN_EP;
            default:    desc_len = LEN_HUB;
        endcase
    endfunction : desc_len

    function automatic logic [7:0] desc_byte(input desc_kind_t  k,
                                             input logic [3:0]  i,
                                             input logic [7:0]  cnt,
                                             input logic [15:0] chr,
                                             input cfg_t        c);
        desc_byte = 8'h00;
        unique case (k)
            KIND_IFACE: begin
                unique case (i)
                    4'h0: desc_byte = LEN_IFACE;
                    4'h1: desc_byte = TYPE_IFACE;
                    4'h2: desc_byte = IFACE_NUM;
                    4'h3: desc_byte = IFACE_ALT;
                    4'h4: desc_byte = IFACE_NUM_EP;
                    4'h5: desc_byte = CLASS_HUB;
                    4'h6: desc_byte = IFACE_SUBCLASS;
                    4'h7: desc_byte = IFACE_PROTO;
                    default: desc_byte = IFACE_STR_IDX;
                endcase
            end
            KIND_EP: begin
                unique case (i)
                    4'h0: desc_byte = LEN_EP;
                    4'h1: desc_byte = TYPE_EP;
                    4'h2: desc_byte = EP_ADDR;
                    4'h3: desc_byte = EP_ATTR;
                    4'h4: desc_byte = EP_MAX_PKT[7:0];
                    4'h5: desc_byte = EP_MAX_PKT[15:8];
                    default: desc_byte = EP_INTERVAL_FS;
                endcase
            end
            default: begin
                // same bytes at either bus speed
                unique case (i)
                    4'h0: desc_byte = LEN_HUB;
                    4'h1: desc_byte = TYPE_HUB;
                    4'h2: desc_byte = cnt;
                    4'h3: desc_byte = chr[7:0];
                    4'h4: desc_byte = chr[15:8];
                    4'h5: desc_byte = c.power_settle;
                    4'h6: desc_byte = c.hub_current;
                    4'h7: desc_byte = c.removable;
                    default: desc_byte = LEGACY_PWR_CTRL;
                endcase
            end
        endcase
    endfunction : desc_byte

    // ----------------------------------------------------------------
    // configuration registers over ahb-lite
    // ----------------------------------------------------------------
    cfg_t        cfg_ff;
    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic        addr_ok;
    logic [7:0]  port_cnt;
    logic [15:0] hub_chars;
    state_t      state_ff;

    assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    // zero wait states, every access answered okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    // reset gives the internal defaults, a bus write is the load path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff.supply_mode_sel        <= RST_SUPPLY;
            cfg_ff.per_port_switch_sel    <= RST_PSW;
            cfg_ff.multi_func             <= RST_MFUNC;
            cfg_ff.overcurrent_sense_mode <= RST_OC;
            cfg_ff.buspow_port_off_mask   <= RST_MASK_BP;
            cfg_ff.selfpow_port_off_mask  <= RST_MASK_SP;
            cfg_ff.power_settle           <= RST_PTIME;
            cfg_ff.hub_current            <= RST_HCUR;
            cfg_ff.removable              <= RST_REMOV;
        end else if (wr_pend_ff) begin
            unique case (wr_addr_ff)
                REG_CFG: begin
                    cfg_ff.supply_mode_sel        <= hwdata[CFG_SUPPLY];
                    cfg_ff.per_port_switch_sel    <= hwdata[CFG_PSW];
                    cfg_ff.multi_func             <= hwdata[CFG_MFUNC];
                    cfg_ff.overcurrent_sense_mode <= hwdata[CFG_OC_LO +: 2];
                end
                REG_MASK: begin
                    cfg_ff.buspow_port_off_mask  <= hwdata[MASK_BP_LO +: 3];
                    cfg_ff.selfpow_port_off_mask <= hwdata[MASK_SP_LO +: 3];
                end
                REG_POWER: begin
                    cfg_ff.power_settle <= hwdata[PWR_TIME_LO +: 8];
                    cfg_ff.hub_current  <= hwdata[PWR_CUR_LO +: 8];
                    cfg_ff.removable    <= hwdata[PWR_REM_LO +: 8];
                end
                default: begin
                end
            endcase
        end
    end

    // read data sampled in the address phase; unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_ff <= 32'h0000_0000;
            unique case (haddr[7:0])
                REG_CFG: begin
                    hrdata_ff[CFG_SUPPLY]     <= cfg_ff.supply_mode_sel;
                    hrdata_ff[CFG_PSW]        <= cfg_ff.per_port_switch_sel;
                    hrdata_ff[CFG_MFUNC]      <= cfg_ff.multi_func;
                    hrdata_ff[CFG_OC_LO +: 2] <= cfg_ff.overcurrent_sense_mode;
                end
                REG_MASK: begin
                    hrdata_ff[MASK_BP_LO +: 3] <= cfg_ff.buspow_port_off_mask;
                    hrdata_ff[MASK_SP_LO +: 3] <= cfg_ff.selfpow_port_off_mask;
                end
                REG_POWER: begin
                    hrdata_ff[PWR_TIME_LO +: 8] <= cfg_ff.power_settle;
                    hrdata_ff[PWR_CUR_LO +: 8]  <= cfg_ff.hub_current;
                    hrdata_ff[PWR_REM_LO +: 8]  <= cfg_ff.removable;
                end
                REG_STATUS: begin
                    hrdata_ff[ST_CNT_LO +: 8] <= port_cnt;
                    hrdata_ff[ST_CHR_LO +: 8] <= hub_chars[7:0];
                    hrdata_ff[ST_BUSY]        <= (state_ff == ST_SEND);
                end
                default: begin
                end
            endcase
        end
    end

    hub_field_calc u_calc (
        .cfg       (cfg_ff),
        .port_cnt  (port_cnt),
        .hub_chars (hub_chars)
    );

    // ----------------------------------------------------------------
    // descriptor streamer
    // ----------------------------------------------------------------
    desc_kind_t kind_ff;
    logic [3:0] idx_ff;
    logic [7:0] out_data_ff;
    logic       out_valid_ff;
    logic       out_last_ff;
    logic       req_reject_ff;
    logic       req_take;
    logic       type_known;
    desc_kind_t req_kind;
    logic       beat;
    logic [3:0] nxt_idx;

    assign req_ready  = (state_ff == ST_IDLE);
    assign req_take   = req_valid && req_ready;
    assign beat       = out_valid_ff && out_ready;
    assign nxt_idx    = idx_ff + 4'h1;
    assign out_valid  = out_valid_ff;
    assign out_data   = out_data_ff;
    assign out_last   = out_last_ff;
    assign req_reject = req_reject_ff;

    always_comb begin
        type_known = 1'b1;
        req_kind   = KIND_HUB;
        unique case (req_type)
            TYPE_IFACE:                req_kind = KIND_IFACE;
            TYPE_EP:                   req_kind = KIND_EP;
            TYPE_HUB, TYPE_HUB_LEGACY: req_kind = KIND_HUB;
            default:                   type_known = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reject_ff <= 1'b0;
        end else begin
            req_reject_ff <= req_take && !type_known;
        end
    end

    // fields are looked up as each byte is loaded, so a config load
    // mid-descriptor can mix old and new values; load while idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff     <= ST_IDLE;
            kind_ff      <= KIND_IFACE;
            idx_ff       <= 4'h0;
            out_valid_ff <= 1'b0;
            out_last_ff  <= 1'b0;
            out_data_ff  <= 8'h00;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (req_take && type_known) begin
                        state_ff     <= ST_SEND;
                        kind_ff      <= req_kind;
                        idx_ff       <= 4'h0;
                        out_valid_ff <= 1'b1;
                        out_last_ff  <= 1'b0;
                        out_data_ff  <= desc_byte(req_kind, 4'h0, port_cnt, hub_chars, cfg_ff);
                    end
                end
                ST_SEND: begin
                    if (beat && out_last_ff) begin
                        state_ff     <= ST_IDLE;
                        out_valid_ff <= 1'b0;
                        out_last_ff  <= 1'b0;
                    end else if (beat) begin
                        idx_ff      <= nxt_idx;
                        out_last_ff <= ({4'h0, nxt_idx} == desc_len(kind_ff) - 8'h01);
                        out_data_ff <= desc_byte(kind_ff, nxt_idx, port_cnt, hub_chars, cfg_ff);
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_IFACE_HEAD: assert property (req_take && req_type == TYPE_IFACE |=>
        out_valid && out_data == 8'h09 && !out_last)
        else $error("interface descriptor does not start with 09h");
    AST_IFACE_CLASS: assert property (out_valid && kind_ff == KIND_IFACE && idx_ff == 4'h5
        |-> out_data == 8'h09)
        else $error("interface class byte is not 09h");
    AST_IFACE_STR: assert property (out_valid && kind_ff == KIND_IFACE && idx_ff == 4'h8
        |-> out_data == 8'h00 && out_last)
        else $error("interface string index wrong or not last");
    AST_EP_ADDR: assert property (out_valid && kind_ff == KIND_EP && idx_ff == 4'h2
        |-> out_data == 8'h81)
        else $error("endpoint address is not 81h");
    AST_EP_ATTR: assert property (out_valid && kind_ff == KIND_EP && idx_ff == 4'h3
        |-> out_data == 8'h03)
        else $error("endpoint attributes byte is not 03h");
    AST_EP_MAXPKT: assert property (beat && kind_ff == KIND_EP && idx_ff == 4'h4
        |-> out_data == 8'h01 ##1 out_data == 8'h00)
        else $error("max packet size not 0001h low byte first");
    AST_EP_INTERVAL: assert property (out_valid && kind_ff == KIND_EP && idx_ff == 4'h6
        |-> out_data == 8'hff && out_last)
        else $error("full-speed interval byte is not ffh");
    AST_HUB_LEGACY: assert property (req_take && req_type == 8'h00 |=>
        out_valid && kind_ff == KIND_HUB && !req_reject)
        else $error("type 00h did not start the hub descriptor");
    AST_HUB_TYPE: assert property (out_valid && kind_ff == KIND_HUB && idx_ff == 4'h1
        |-> out_data == 8'h29)
        else $error("hub descriptor type byte is not 29h");
    AST_PORT_CNT: assert property (out_valid && kind_ff == KIND_HUB && idx_ff == 4'h2
        |-> out_data == 8'(3 - $countones(cfg_ff.supply_mode_sel ?
            cfg_ff.selfpow_port_off_mask : cfg_ff.buspow_port_off_mask)))
        else $error("port count does not match active disable mask");
    AST_HUB_CHARS: assert property (out_valid && kind_ff == KIND_HUB && idx_ff == 4'h3
        |-> out_data[1:0] == {1'b0, cfg_ff.per_port_switch_sel} && out_data[7:5] == 3'h0
            && out_data[4:2] == {cfg_ff.overcurrent_sense_mode, cfg_ff.multi_func})
        else $error("hub characteristics low byte wrong");
    AST_HUB_POWER: assert property (out_valid && kind_ff == KIND_HUB && idx_ff == 4'h5
        |-> out_data == cfg_ff.power_settle)
        else $error("power-on-to-good byte differs from stored time");
    AST_REJECT: assert property (req_take && !(req_type inside {8'h04, 8'h05, 8'h29, 8'h00})
        |=> req_reject && !out_valid)
        else $error("unknown descriptor type not rejected");

    COV_IFACE: cover property (beat && out_last && kind_ff == KIND_IFACE);
    COV_EP: cover property (beat && out_last && kind_ff == KIND_EP);
    COV_HUB_LEGACY: cover property (req_take && req_type == 8'h00 ##[1:40] beat && out_last);
    COV_REJECT: cover property (req_reject);

endmodule : hub_fs_descriptor_source

// ===== common/hub_desc_pkg.sv
// constants, types and field layout for the full-speed hub descriptor source
// Contract
// - interface descriptor: length 09h, type 04h, interface 00h, alternate 00h
// - interface has one endpoint, class 09h, subclass 00h, protocol 00h
// - interface string index byte is 00h
// - endpoint descriptor: length 07h, type 05h, address 81h (EP1 IN)
// - endpoint attributes byte is 03h, interrupt, no synchronization
// - endpoint max packet size is the two-byte value 0001h
// - full-speed endpoint polling interval byte is FFh
// - hub descriptor is returned for requested type 29h and for 00h
// - hub descriptor serves both speeds and starts with 09h then 29h
// - port count equals 3 minus ports flagged disabled in the active mask
// - supply mode 0 selects bus-powered mask, 1 selects self-powered mask
// - characteristics D1:0 is 00b when power switching is 0, 01b when 1
// - D2 copies multi-function flag, D4:3 copy over-current sense mode
// - characteristics D6:5 are 00b, think time of 8 FS bit times
// - D7 is zero, no port indicators, and D15:8 are all zero
// - power-on-to-good byte reports stored settle time unchanged, 2 ms units
// - configurable fields come from reset defaults or a configuration load
// - supply mode 0 means bus-powered, 1 means self-powered
package hub_desc_pkg;

    // ----------------------------------------------------------------
    // descriptor constants
    // ----------------------------------------------------------------
    localparam logic [7:0]  TYPE_IFACE      = 8'h04;
    localparam logic [7:0]  TYPE_EP         = 8'h05;
    localparam logic [7:0]  TYPE_HUB        = 8'h29;
    localparam logic [7:0]  TYPE_HUB_LEGACY = 8'h00;
    localparam logic [7:0]  LEN_IFACE       = 8'h09;
    localparam logic [7:0]  LEN_EP          = 8'h07;
    localparam logic [7:0]  LEN_HUB         = 8'h09;
    localparam logic [7:0]  IFACE_NUM       = 8'h00;
    localparam logic [7:0]  IFACE_ALT       = 8'h00;
    localparam logic [7:0]  IFACE_NUM_EP    = 8'h01;
    localparam logic [7:0]  CLASS_HUB       = 8'h09;
    localparam logic [7:0]  IFACE_SUBCLASS  = 8'h00;
    localparam logic [7:0]  IFACE_PROTO     = 8'h00;
    localparam logic [7:0]  IFACE_STR_IDX   = 8'h00;
    localparam logic [7:0]  EP_ADDR         = 8'h81;
    localparam logic [7:0]  EP_ATTR         = 8'h03;
    localparam logic [15:0] EP_MAX_PKT      = 16'h0001;
    localparam logic [7:0]  EP_INTERVAL_FS  = 8'hff;
    localparam logic [7:0]  LEGACY_PWR_CTRL = 8'hff;
    localparam logic [1:0]  TOTAL_PORTS     = 2'h3;
    localparam logic [1:0]  PWR_SW_GANGED   = 2'h0;
    localparam logic [1:0]  PWR_SW_PERPORT  = 2'h1;
    localparam logic [1:0]  TT_THINK_8FS    = 2'h0;
    localparam logic        PORT_IND_NONE   = 1'h0;
    localparam logic [7:0]  CHARS_HIGH      = 8'h00;

    // ----------------------------------------------------------------
    // register map (byte addresses) and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CFG     = 8'h00;
    localparam logic [7:0]  REG_MASK    = 8'h04;
    localparam logic [7:0]  REG_POWER   = 8'h08;
    localparam logic [7:0]  REG_STATUS  = 8'h0c;
    localparam int          CFG_SUPPLY  = 0;
    localparam int          CFG_PSW     = 1;
    localparam int          CFG_MFUNC   = 2;
    localparam int          CFG_OC_LO   = 3;
    localparam int          MASK_BP_LO  = 0;
    localparam int          MASK_SP_LO  = 8;
    localparam int          PWR_TIME_LO = 0;
    localparam int          PWR_CUR_LO  = 8;
    localparam int          PWR_REM_LO  = 16;
    localparam int          ST_CNT_LO   = 0;
    localparam int          ST_CHR_LO   = 8;
    localparam int          ST_BUSY     = 24;

    // reset defaults
    localparam logic        RST_SUPPLY  = 1'h1;
    localparam logic        RST_PSW     = 1'h1;
    localparam logic        RST_MFUNC   = 1'h0;
    localparam logic [1:0]  RST_OC      = 2'h1;
    localparam logic [2:0]  RST_MASK_BP = 3'h0;
    localparam logic [2:0]  RST_MASK_SP = 3'h0;
    localparam logic [7:0]  RST_PTIME   = 8'h32;
    localparam logic [7:0]  RST_HCUR    = 8'h01;
    localparam logic [7:0]  RST_REMOV   = 8'h00;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       supply_mode_sel;
        logic       per_port_switch_sel;
        logic       multi_func;
        logic [1:0] overcurrent_sense_mode;
        logic [2:0] buspow_port_off_mask;
        logic [2:0] selfpow_port_off_mask;
        logic [7:0] power_settle;
        logic [7:0] hub_current;
        logic [7:0] removable;
    } cfg_t;

    typedef enum logic [1:0] {
        KIND_IFACE,
        KIND_EP,
        KIND_HUB
    } desc_kind_t;

    typedef enum logic {
        ST_IDLE,
        ST_SEND
    } state_t;

endpackage : hub_desc_pkg

// ===== design/hub_field_calc.sv
// derived hub descriptor fields: port count and hub characteristics
module hub_field_calc
    import hub_desc_pkg::*;
(
    input  wire hub_desc_pkg::cfg_t cfg,
    output logic [7:0]              port_cnt,
    output logic [15:0]             hub_chars
);

    function automatic logic [1:0] ones3(input logic [2:0] m);
        ones3 = {1'b0, m[0]} + {1'b0, m[1]} + {1'b0, m[2]};
    endfunction : ones3

    logic [2:0] active_mask;

    // mode 0 is bus-powered, mode 1 self-powered
    assign active_mask = cfg.supply_mode_sel ? cfg.selfpow_port_off_mask
                                             : cfg.buspow_port_off_mask;
    // mask of all ones never underflows: 3 - 3 = 0
    assign port_cnt    = {6'h00, TOTAL_PORTS - ones3(active_mask)};

    assign hub_chars   = {CHARS_HIGH,
                          PORT_IND_NONE,
                          TT_THINK_8FS,
                          cfg.overcurrent_sense_mode,
                          cfg.multi_func,
                          cfg.per_port_switch_sel ? PWR_SW_PERPORT
                                                  : PWR_SW_GANGED};

endmodule : hub_field_calc

// ===== dv/desc_host_model.sv
// host-side model that requests descriptors and collects the returned bytes
module desc_host_model (
    input  wire logic       hclk,
    input  wire logic       start,
    input  wire logic [7:0] kind,
    input  wire logic       stall,
    input  wire logic       req_ready,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic       out_last,
    output logic            req_valid,
    output logic [7:0]      req_type,
    output logic            out_ready,
    output logic            done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got[$];
    logic       ph;
    initial begin
        {req_valid, req_type, out_ready, done, ph} = '0;
    end
    always @(posedge hclk) begin
        ph <= ~ph;
        out_ready <= !stall || ph;
        // request held until taken, then type scrambled so a late look fails
        if (req_valid && req_ready) begin
            req_valid <= 1'b0;
            req_type <= ~req_type;
        end else if (start) begin
            req_valid <= 1'b1;
            req_type <= kind;
            done <= 1'b0;
            got.delete();
        end
        if (out_valid && out_ready) begin
            got.push_back(out_data);
            if (out_last) done <= 1'b1;
        end
    end
endmodule : desc_host_model

// ===== dv/tb_hub_fs_descriptor_source.sv
// self-checking bench for the descriptor source
module tb_hub_fs_descriptor_source;
    import hub_desc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, req_ready, req_reject;
    logic        out_valid, out_last, out_ready, req_valid, start, stall, done;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  out_data, req_type, kind, np, ch;
    logic [7:0]  ex[9];
    logic [31:0] cf[2] = '{32'h00, 32'h1f};
    logic [31:0] mk[2] = '{32'h0305, 32'h0105};
    logic [31:0] pw[2] = '{32'h05a7, 32'h030c02};
    int          fail_count = 0, tests_run = 0, rej, ov;

    hub_fs_descriptor_source dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .req_valid(req_valid), .req_type(req_type), .req_ready(req_ready),
        .req_reject(req_reject), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready));
    desc_host_model host (.hclk(hclk), .start(start), .kind(kind), .stall(stall),
        .req_ready(req_ready), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .req_valid(req_valid), .req_type(req_type),
        .out_ready(out_ready), .done(done));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // bus and descriptor access
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
        if (k >= 50) begin fail_count++; end_sim(); end
    endtask : xfer

    task automatic fetch(input logic [7:0] t, input int n, input logic s);
        int k;
        k = 0;
        @(posedge hclk);
        start <= 1'b1;
        kind <= t;
        stall <= s;
        @(posedge hclk);
        start <= 1'b0;
        do begin @(negedge hclk); k++; end while (done !== 1'b1 && k < 100);
        if (done !== 1'b1) begin fail_count++; end_sim(); end
        `CHK(host.got.size(), n)
        for (int j = 0; j < n; j++) `CHK(host.got[j], ex[j])
    endtask : fetch

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {hresetn, hsel, htrans, haddr, hwrite, hwdata, start, kind, stall} = '0;
        hsize = 3'h2;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, REG_STATUS, 32'h0); `CHK(rd, 32'h0903)
        xfer(1'b0, REG_CFG, 32'h0); `CHK(rd, 32'h0b)
        xfer(1'b0, 8'h10, 32'h0); `CHK({rd, hresp}, 33'h0)
        ex = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00};
        fetch(TYPE_IFACE, 9, 1'b1);
        ex = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hff, 8'h00, 8'h00};
        fetch(TYPE_EP, 7, 1'b0);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, REG_CFG, cf[i]);
            xfer(1'b1, REG_MASK, mk[i]);
            xfer(1'b1, REG_POWER, pw[i]);
            np = 8'd3 - 8'($countones(cf[i][0] ? mk[i][10:8] : mk[i][2:0]));
            ch = {3'b000, cf[i][4:3], cf[i][2], 1'b0, cf[i][1]};
            xfer(1'b0, REG_STATUS, 32'h0); `CHK(rd[15:0], {ch, np})
            ex = '{8'h09, 8'h29, np, ch, 8'h00, pw[i][7:0], pw[i][15:8], pw[i][23:16], 8'hff};
            fetch(i ? TYPE_HUB : TYPE_HUB_LEGACY, 9, i[0]);
        end
        {rej, ov} = '0;
        @(posedge hclk);
        start <= 1'b1;
        kind <= 8'h07;
        @(posedge hclk);
        start <= 1'b0;
        repeat (8) begin @(negedge hclk); rej += req_reject; ov += out_valid; end
        `CHK({rej, ov}, {32'd1, 32'd0})
        end_sim();
    end
endmodule : tb_hub_fs_descriptor_source
